//--- cgrc_chk.sv
// Checker: bus timing and output relations
`timescale 1ns/10ps
module cgrc_chk import cgrc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] main_source,
    input wire logic [1:0] main_divider,
    input wire logic main_trim_active,
    input wire logic fll_ref_external,
    input wire logic loss_reset_req,
    input wire logic loss_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence done_s;
        psel && penable && pready;
    endsequence
    sequence wr1_s;
        done_s ##0 pwrite && paddr == OFS_CTRL1;
    endsequence
    chk_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("late pready");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("bad pready");
    chk_unmapped_err: assert property (done_s ##0 (paddr > OFS_CTRL3 || paddr[1:0] != 2'h0)
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    chk_div_apply: assert property (done_s ##0 pwrite && paddr == OFS_CTRL2
        |-> ##2 main_divider == $past(pwdata[7:6], 2)) else $error("divider not applied");
    chk_ref_select: assert property (wr1_s ##0 pwdata[2] |-> ##[1:3] !fll_ref_external)
        else $error("external still on loop");
    chk_ext_no_trim: assert property (main_source == SRC_EXT |-> !main_trim_active)
        else $error("trim active on external source");
    chk_reset_mode: assert property (disable iff (1'b0) !rst_n ##1 !rst_n
        |-> main_divider == DIV_BY2 && main_source == SRC_FLL) else $error("bad reset mode");
    chk_loss_sticky: assert property (disable iff (!por_n) loss_reset_req || loss_flag
        |=> loss_flag) else $error("loss flag not held");
endmodule
bind cgrc_top cgrc_chk cgrc_chk_i (.*);

//--- cgrc_pkg.sv
// Package: map, fields, resets and timing
package cgrc_pkg;

    localparam int unsigned CLK_MHZ = 50;

    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_TRIM = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CTRL3 = 8'h10;

    localparam logic [1:0] SRC_FLL = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_PLL = 2'h3;

    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [2:0] REFERENCE_DIVIDER_MIN_BY1 = 3'h2;
    localparam logic [2:0] REFERENCE_DIVIDER_MIN_BY2 = 3'h3;

    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] CTRL2_RST = 8'h40;
    localparam logic [7:0] CTRL3_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic FINE_TRIM_BIT_RST = 1'b0;

    localparam int unsigned CNT_W = 20;
    localparam int unsigned IREF_STAB_US = 10;
    localparam int unsigned IREF_STAB_CYC = IREF_STAB_US * CLK_MHZ;
    localparam int unsigned FLL_LOCK_US = 1000;
    localparam int unsigned FLL_LOCK_CYC = FLL_LOCK_US * CLK_MHZ;
    localparam int unsigned LOC_HIGH_US = 4;
    localparam int unsigned LOC_HIGH_CYC = LOC_HIGH_US * CLK_MHZ;
    localparam int unsigned LOC_LOW_US = 200;
    localparam int unsigned LOC_LOW_CYC = LOC_LOW_US * CLK_MHZ;
    localparam logic [12:0] OSC_INIT_EDGES = 13'h1000;

    typedef struct packed {
        logic [1:0] system_source_select;
        logic [2:0] reference_divider;
        logic internal_ref_select;
        logic internal_ref_output_enable;
        logic internal_ref_stop_enable;
    } cgrc_ctrl1_t;

    typedef struct packed {
        logic [1:0] output_divider;
        logic freq_range;
        logic high_gain;
        logic fll_pll_power_down;
        logic crystal_select;
        logic external_ref_output_enable;
        logic external_ref_stop_enable;
    } cgrc_ctrl2_t;

    typedef struct packed {
        logic rsvd_hi;
        logic pll_select;
        logic clock_monitor_enable;
        logic [4:0] rsvd_lo;
    } cgrc_ctrl3_t;

    typedef struct packed {
        logic loss_flag;
        logic fll_lock;
        logic pll_status;
        logic int_ref_status;
        logic [1:0] system_source_status;
        logic oscillator_ready;
        logic fine_trim_bit;
    } cgrc_status_t;

endpackage

//--- cgrc_ref_sampler.sv
// Two-flop synchroniser with rise pulse
`timescale 1ns/10ps
module cgrc_ref_sampler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d_in,
    output logic level,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Edge uses stages two and three only
    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;
endmodule

//--- cgrc_top.sv
// Reference clock control block
//
// Functional notes
// R1 - Power-down bit stops FLL/PLL in bypass modes
// R2 - Internal reference driven out when enabled
// R3 - Larger trim lowers internal reference frequency
// R4 - Trim affects main clock only internally
// R5 - Trim values reset only by power-on; trim_code output register also reloads TRIM_RST on system reset
// R6 - Internal reference runs in stop if enabled
// R7 - External reference driven out when enabled
// R8 - Internal select keeps external off the loop
// R9 - External reference runs in stop when needed
// R10 - Clock loss resets chip and flags cause
// R11 - Fixed clock invalid for listed divider combinations
// R12 - Reset gives FLL engaged internal, divide-by-2
// R13 - Lock starts after reference stabilisation delay
// R14 - Software copies trim values from flash
// R15 - No divide-by-1 before trimming
// R16 - From reset only three direct mode switches
// R17 - External engaged entry write sequence
// R18 - External bypassed entry write sequence
// R19 - Poll oscillator ready after crystal select
// R20 - Check status clear and lock set
// R21 - Bypassed external keeps FLL locking, software checks
// R22 - Source status reports internal once selected
// R23 - Status shows actual source, unavailable keeps previous
// R24 - Output divider change applies immediately
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module cgrc_top import cgrc_pkg::*; #(
    parameter int unsigned LOCK_CYC = FLL_LOCK_CYC,
    parameter int unsigned LOC_LOW_LIMIT = LOC_LOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic int_ref_clk_in,
    input wire logic ext_ref_clk_in,
    input wire logic stop_mode,
    output logic internal_ref_clock_out,
    output logic external_ref_clock_out,
    output logic fixed_freq_clock_out,
    output logic fixed_freq_valid,
    output logic [1:0] main_source,
    output logic [1:0] main_divider,
    output logic main_trim_active,
    output logic [7:0] trim_code,
    output logic fine_trim,
    output logic fll_ref_external,
    output logic fll_enable,
    output logic pll_enable,
    output logic int_osc_enable,
    output logic ext_osc_enable,
    output logic loss_reset_req,
    output logic loss_flag
);

    function automatic logic ext_loop_mode(input logic [1:0] sel, input logic iref);
        // Engaged or bypassed external modes, with or without low power
        return !iref && (sel != SRC_INT);
    endfunction

    function automatic logic int_main_mode(input logic [1:0] sel, input logic iref,
                                           input logic pll);
        return (sel == SRC_INT) || (sel == SRC_FLL && iref && !pll);
    endfunction

    function automatic logic ff_tap(input logic [6:0] cnt, input logic [2:0] div,
                                    input logic lvl);
        logic r;
        r = lvl;
        if (div != 3'h0) begin
            r = cnt[div - 3'h1];
        end
        return r;
    endfunction

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic por_meta_reg;
    logic por_sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            por_meta_reg <= 1'b0;
            por_sync_reg <= 1'b0;
        end else begin
            por_meta_reg <= 1'b1;
            por_sync_reg <= por_meta_reg;
        end
    end

    logic int_lvl;
    logic int_rise;
    logic ext_lvl;
    logic ext_rise;
    logic stop_lvl;

    cgrc_ref_sampler u_int_ref (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .d_in(int_ref_clk_in),
        .level(int_lvl),
        .rise(int_rise)
    );

    cgrc_ref_sampler u_ext_ref (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .d_in(ext_ref_clk_in),
        .level(ext_lvl),
        .rise(ext_rise)
    );

    cgrc_ref_sampler u_stop (
        .clk(clk),
        .rst_n(rst_sync_reg),
        .d_in(stop_mode),
        .level(stop_lvl),
        .rise()
    );

    // Register file and bus slave
    cgrc_ctrl1_t ctrl1_reg, ctrl1_next;
    cgrc_ctrl2_t ctrl2_reg, ctrl2_next;
    cgrc_ctrl3_t ctrl3_reg, ctrl3_next;
    logic [7:0] trim_reg, trim_next;
    logic fine_trim_bit_reg, fine_trim_bit_next;
    logic loss_flag_reg, loss_flag_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    cgrc_status_t status;
    logic loss_req_reg;
    logic wr_en;
    logic hit;
    logic [7:0] rd_byte;

    always_comb begin
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        ctrl3_next = ctrl3_reg;
        trim_next = trim_reg;
        fine_trim_bit_next = fine_trim_bit_reg;
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (paddr)
            OFS_CTRL1: rd_byte = ctrl1_reg;
            OFS_CTRL2: rd_byte = ctrl2_reg;
            OFS_TRIM: rd_byte = trim_reg;
            OFS_STATUS: rd_byte = status;
            OFS_CTRL3: rd_byte = {1'b0, ctrl3_reg.pll_select,
                                  ctrl3_reg.clock_monitor_enable, 5'h00};
            default: hit = 1'b0;
        endcase
        // One wait state
        pready_next = psel && penable && !pready_reg;
        pslverr_next = pready_next && !hit;
        prdata_next = prdata_reg;
        if (pready_next) begin
            prdata_next = hit ? {24'h000000, rd_byte} : 32'h00000000;
        end
        wr_en = psel && penable && pwrite && pready_reg && !pslverr_reg;
        if (wr_en) begin
            unique case (paddr)
                OFS_CTRL1: ctrl1_next = pwdata[7:0];
                // R24 divider taken without handshake
                OFS_CTRL2: ctrl2_next = pwdata[7:0];
                OFS_CTRL3: ctrl3_next = {1'b0, pwdata[6:5], 5'h00};
                OFS_TRIM: trim_next = pwdata[7:0];
                OFS_STATUS: fine_trim_bit_next = pwdata[0];
                default: ;
            endcase
        end
        // R10 loss flag survives the reset it causes
        loss_flag_next = loss_flag_reg || loss_req_reg;
    end

    // R12 reset mode and divider
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ctrl1_reg <= CTRL1_RST;
            ctrl2_reg <= CTRL2_RST;
            ctrl3_reg <= CTRL3_RST;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
            ctrl3_reg <= ctrl3_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // R5 power-on reset only
    always_ff @(posedge clk or negedge por_sync_reg) begin
        if (!por_sync_reg) begin
            trim_reg <= TRIM_RST;
            fine_trim_bit_reg <= FINE_TRIM_BIT_RST;
            loss_flag_reg <= 1'b0;
        end else begin
            trim_reg <= trim_next;
            fine_trim_bit_reg <= fine_trim_bit_next;
            loss_flag_reg <= loss_flag_next;
        end
    end

    // Sequencing
    logic [CNT_W-1:0] stab_cnt_reg, stab_cnt_next;
    logic [CNT_W-1:0] lock_cnt_reg, lock_cnt_next;
    logic [CNT_W-1:0] mon_cnt_reg, mon_cnt_next;
    logic [12:0] osc_cnt_reg, osc_cnt_next;
    logic osc_ready_reg, osc_ready_next;
    logic lock_reg, lock_next;
    logic iref_st_reg, iref_st_next;
    logic pll_st_reg, pll_st_next;
    logic [1:0] src_st_reg, src_st_next;
    logic loss_req_next;
    logic iref_prev_reg;
    logic int_en, ext_en, iref_stable, ext_avail, loop_on, ref_ok, src_avail;
    logic [1:0] src_target;
    logic [CNT_W-1:0] mon_limit;

    always_comb begin
        int_en = ctrl1_reg.internal_ref_select || ctrl1_reg.internal_ref_output_enable
                 || ctrl1_reg.system_source_select == SRC_INT;
        ext_en = ctrl2_reg.external_ref_output_enable
                 || ext_loop_mode(ctrl1_reg.system_source_select,
                                  ctrl1_reg.internal_ref_select);
        iref_stable = stab_cnt_reg == CNT_W'(IREF_STAB_CYC);
        stab_cnt_next = !int_en ? '0 : iref_stable ? stab_cnt_reg : stab_cnt_reg + 1'b1;
        // Crystal needs start-up edges; a plain external clock is ready at once
        osc_cnt_next = osc_cnt_reg;
        if (!ext_en || !ctrl2_reg.crystal_select) begin
            osc_cnt_next = 13'h0000;
        end else if (ext_rise && osc_cnt_reg != OSC_INIT_EDGES) begin
            osc_cnt_next = osc_cnt_reg + 13'h0001;
        end
        osc_ready_next = ext_en && ctrl2_reg.crystal_select
                         && osc_cnt_reg == OSC_INIT_EDGES;
        ext_avail = ext_en && (!ctrl2_reg.crystal_select || osc_ready_reg);
        // R1 power-down in bypass
        loop_on = !stop_lvl && !(ctrl2_reg.fll_pll_power_down
                  && ctrl1_reg.system_source_select != SRC_FLL);
        // R8 loop reference choice
        ref_ok = ctrl1_reg.internal_ref_select ? iref_stable : ext_avail;
        // R13 lock after stable reference
        // R21 locking while bypassed
        lock_cnt_next = lock_cnt_reg;
        if (!loop_on || !ref_ok || iref_prev_reg != ctrl1_reg.internal_ref_select) begin
            lock_cnt_next = '0;
        end else if (lock_cnt_reg != CNT_W'(LOCK_CYC)) begin
            lock_cnt_next = lock_cnt_reg + 1'b1;
        end
        lock_next = loop_on && ref_ok && lock_cnt_reg == CNT_W'(LOCK_CYC);
        iref_st_next = iref_st_reg;
        if (ctrl1_reg.internal_ref_select && iref_stable) begin
            iref_st_next = 1'b1;
        end else if (!ctrl1_reg.internal_ref_select && ext_avail) begin
            iref_st_next = 1'b0;
        end
        pll_st_next = ctrl3_reg.pll_select;
        src_target = ctrl1_reg.system_source_select;
        src_avail = 1'b0;
        unique case (ctrl1_reg.system_source_select)
            SRC_FLL: begin
                src_avail = ctrl3_reg.pll_select ? ext_avail : 1'b1;
                src_target = ctrl3_reg.pll_select ? SRC_PLL : SRC_FLL;
            end
            // R22 internal once running
            SRC_INT: src_avail = iref_stable;
            SRC_EXT: src_avail = ext_avail;
            SRC_PLL: src_avail = 1'b0;
        endcase
        // R23 keep previous source
        src_st_next = src_avail ? src_target : src_st_reg;
        // R10 armed once reference runs
        mon_limit = ctrl2_reg.freq_range ? CNT_W'(LOC_HIGH_CYC) : CNT_W'(LOC_LOW_LIMIT);
        mon_cnt_next = '0;
        loss_req_next = 1'b0;
        if (ctrl3_reg.clock_monitor_enable && ext_avail && !stop_lvl && !ext_rise) begin
            mon_cnt_next = mon_cnt_reg + 1'b1;
            if (mon_cnt_reg == mon_limit) begin
                mon_cnt_next = '0;
                loss_req_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            stab_cnt_reg <= '0;
            lock_cnt_reg <= '0;
            mon_cnt_reg <= '0;
            osc_cnt_reg <= 13'h0000;
            osc_ready_reg <= 1'b0;
            lock_reg <= 1'b0;
            iref_st_reg <= 1'b1;
            pll_st_reg <= 1'b0;
            src_st_reg <= SRC_FLL;
            loss_req_reg <= 1'b0;
            iref_prev_reg <= 1'b1;
        end else begin
            stab_cnt_reg <= stab_cnt_next;
            lock_cnt_reg <= lock_cnt_next;
            mon_cnt_reg <= mon_cnt_next;
            osc_cnt_reg <= osc_cnt_next;
            osc_ready_reg <= osc_ready_next;
            lock_reg <= lock_next;
            iref_st_reg <= iref_st_next;
            pll_st_reg <= pll_st_next;
            src_st_reg <= src_st_next;
            loss_req_reg <= loss_req_next;
            iref_prev_reg <= ctrl1_reg.internal_ref_select;
        end
    end

    always_comb begin
        status.loss_flag = loss_flag_reg;
        status.fll_lock = lock_reg;
        status.pll_status = pll_st_reg;
        status.int_ref_status = iref_st_reg;
        status.system_source_status = src_st_reg;
        status.oscillator_ready = osc_ready_reg;
        status.fine_trim_bit = fine_trim_bit_reg;
    end

    // Output stage
    logic [6:0] ff_cnt_reg, ff_cnt_next;
    logic int_out_reg, int_out_next;
    logic ext_out_reg, ext_out_next;
    logic ff_out_reg, ff_out_next;
    logic ff_valid_reg, ff_valid_next;
    logic trim_act_reg, trim_act_next;
    logic fll_ext_reg, fll_ext_next;
    logic fll_en_reg, fll_en_next;
    logic pll_en_reg, pll_en_next;
    logic int_osc_reg, int_osc_next;
    logic ext_osc_reg, ext_osc_next;
    logic [1:0] main_src_reg;
    logic [1:0] main_div_reg;
    logic [7:0] trim_out_reg;
    logic fine_trim_bit_out_reg;
    logic loss_out_reg;
    logic loss_flag_out_reg;
    logic ff_lvl, ff_rise, bypass, ext_run;

    always_comb begin
        // R6 stop run needs both enables
        int_osc_next = int_en && (!stop_lvl || (ctrl1_reg.internal_ref_output_enable
                       && ctrl1_reg.internal_ref_stop_enable));
        // R9 stop run by enables or mode
        ext_run = !stop_lvl || (ctrl2_reg.external_ref_output_enable
                  && ctrl2_reg.external_ref_stop_enable)
                  || ext_loop_mode(ctrl1_reg.system_source_select,
                                   ctrl1_reg.internal_ref_select);
        ext_osc_next = ext_en && ext_run;
        // R2 internal out
        int_out_next = int_lvl && ctrl1_reg.internal_ref_output_enable && int_osc_next;
        // R7 external out
        ext_out_next = ext_lvl && ctrl2_reg.external_ref_output_enable && ext_osc_next;
        // R8 loop reference steering
        fll_ext_next = !ctrl1_reg.internal_ref_select;
        // R1 loop power
        fll_en_next = loop_on && !ctrl3_reg.pll_select;
        pll_en_next = loop_on && ctrl3_reg.pll_select;
        // R4 internal modes only
        trim_act_next = int_main_mode(ctrl1_reg.system_source_select,
                                      ctrl1_reg.internal_ref_select, ctrl3_reg.pll_select);
        ff_lvl = ctrl1_reg.internal_ref_select ? int_lvl : ext_lvl;
        ff_rise = ctrl1_reg.internal_ref_select ? int_rise : ext_rise;
        ff_cnt_next = ff_rise ? ff_cnt_reg + 7'h01 : ff_cnt_reg;
        ff_out_next = ff_tap(ff_cnt_reg, ctrl1_reg.reference_divider, ff_lvl);
        // R11 fixed clock validity
        bypass = ctrl1_reg.system_source_select != SRC_FLL;
        ff_valid_next = !(bypass && ((ctrl2_reg.output_divider == DIV_BY1
                          && ctrl1_reg.reference_divider < REFERENCE_DIVIDER_MIN_BY1)
                          || (ctrl2_reg.output_divider == DIV_BY2
                          && ctrl1_reg.reference_divider < REFERENCE_DIVIDER_MIN_BY2)));
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ff_cnt_reg <= 7'h00;
            int_out_reg <= 1'b0;
            ext_out_reg <= 1'b0;
            ff_out_reg <= 1'b0;
            ff_valid_reg <= 1'b1;
            trim_act_reg <= 1'b1;
            fll_ext_reg <= 1'b0;
            fll_en_reg <= 1'b0;
            pll_en_reg <= 1'b0;
            int_osc_reg <= 1'b1;
            ext_osc_reg <= 1'b0;
            main_src_reg <= SRC_FLL;
            main_div_reg <= DIV_BY2;
            trim_out_reg <= TRIM_RST;
            fine_trim_bit_out_reg <= FINE_TRIM_BIT_RST;
            loss_out_reg <= 1'b0;
            loss_flag_out_reg <= 1'b0;
        end else begin
            ff_cnt_reg <= ff_cnt_next;
            int_out_reg <= int_out_next;
            ext_out_reg <= ext_out_next;
            ff_out_reg <= ff_out_next;
            ff_valid_reg <= ff_valid_next;
            trim_act_reg <= trim_act_next;
            fll_ext_reg <= fll_ext_next;
            fll_en_reg <= fll_en_next;
            pll_en_reg <= pll_en_next;
            int_osc_reg <= int_osc_next;
            ext_osc_reg <= ext_osc_next;
            main_src_reg <= src_st_reg;
            main_div_reg <= ctrl2_reg.output_divider;
            // R3 trim to oscillator
            trim_out_reg <= trim_reg;
            fine_trim_bit_out_reg <= fine_trim_bit_reg;
            loss_out_reg <= loss_req_reg;
            loss_flag_out_reg <= loss_flag_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign internal_ref_clock_out = int_out_reg;
    assign external_ref_clock_out = ext_out_reg;
    assign fixed_freq_clock_out = ff_out_reg;
    assign fixed_freq_valid = ff_valid_reg;
    assign main_source = main_src_reg;
    assign main_divider = main_div_reg;
    assign main_trim_active = trim_act_reg;
    assign trim_code = trim_out_reg;
    assign fine_trim = fine_trim_bit_out_reg;
    assign fll_ref_external = fll_ext_reg;
    assign fll_enable = fll_en_reg;
    assign pll_enable = pll_en_reg;
    assign int_osc_enable = int_osc_reg;
    assign ext_osc_enable = ext_osc_reg;
    assign loss_reset_req = loss_out_reg;
    assign loss_flag = loss_flag_out_reg;
endmodule

//--- tb_top.sv
// Testbench: registers, reset, modes, outputs
`timescale 1ns/10ps
module tb_top import cgrc_pkg::*;;
    logic clk = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0;
    logic int_ref_clk_in = 0, ext_ref_clk_in = 0, ext_run = 1, er;
    logic [7:0] paddr = 0, trim_code;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] cnt = 0;
    logic [1:0] main_source, main_divider;
    logic pready, pslverr, internal_ref_clock_out, external_ref_clock_out, fixed_freq_clock_out;
    logic fixed_freq_valid, main_trim_active, fine_trim, fll_ref_external, fll_enable;
    logic pll_enable, int_osc_enable, ext_osc_enable, loss_reset_req, loss_flag;
    int err_count = 0, checks = 0, n;
    cgrc_top #(.LOCK_CYC(64), .LOC_LOW_LIMIT(100)) cgrc_top_i (.*);
    initial begin
        forever #10 clk = ~clk;
    end
    // External reference can stop for a loss
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
        int_ref_clk_in <= cnt[3];
        ext_ref_clk_in <= cnt[1] & ext_run;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task poll(input logic [7:0] m, input logic [7:0] v);
        n = 0;
        rd = 0;
        while ((rd[7:0] & m) !== v && n < 2000) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
    endtask
    task do_reset(input logic p);
        rst_n <= 1'b0;
        por_n <= ~p;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    function logic pick(input logic x);
        return x ? external_ref_clock_out : internal_ref_clock_out;
    endfunction
    // Settle past output lag, count changes
    task edges(input logic x, output int k);
        logic p;
        k = 0;
        repeat (8) @(posedge clk);
        p = pick(x);
        repeat (40) begin
            @(posedge clk);
            if (pick(x) !== p) k++;
            p = pick(x);
        end
    endtask
    task print_verdict;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        print_verdict;
    end
    initial begin
        do_reset(1'b1);
        rdc("ctrl1", OFS_CTRL1, 32'h4);
        rdc("ctrl2", OFS_CTRL2, 32'h40);
        rdc("ctrl3", OFS_CTRL3, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", er, 1'b1);
        $display("test reset done");
        apb(1'b1, OFS_TRIM, 32'h3C);
        do_reset(1'b0);
        rdc("trim kept", OFS_TRIM, 32'h3C);
        chk("trim code", trim_code, 8'h3C);
        do_reset(1'b1);
        rdc("trim por", OFS_TRIM, 32'h80);
        $display("test trim done");
        apb(1'b1, OFS_CTRL1, 32'h47);
        poll(8'h0C, 8'h04);
        chk("src status", rd[3:2], SRC_INT);
        chk("trim active", main_trim_active, 1'b1);
        edges(1'b0, n);
        chk("iref out", n > 0, 1'b1);
        stop_mode <= 1'b1;
        edges(1'b0, n);
        chk("iref in stop", n > 0, 1'b1);
        apb(1'b1, OFS_CTRL1, 32'h46);
        edges(1'b0, n);
        chk("iref stopped", n, 0);
        stop_mode <= 1'b0;
        $display("test internal done");
        apb(1'b1, OFS_TRIM, 32'h7F);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_CTRL1, {24'h0, 2'h1, 3'(1 + i[0] + i[1]), 3'h6});
            apb(1'b1, OFS_CTRL2, {24'h0, 1'b0, i[1], 6'h0});
            repeat (4) @(posedge clk);
            chk("divider", main_divider, {1'b0, i[1]});
            chk("ff valid", fixed_freq_valid, i[0]);
        end
        apb(1'b1, OFS_CTRL2, 32'h48);
        repeat (4) @(posedge clk);
        chk("fll off", fll_enable, 1'b0);
        apb(1'b1, OFS_CTRL2, 32'h40);
        repeat (4) @(posedge clk);
        chk("fll on", fll_enable, 1'b1);
        $display("test divider done");
        apb(1'b1, OFS_CTRL2, 32'h42);
        apb(1'b1, OFS_CTRL1, 32'h80);
        poll(8'h5C, 8'h48);
        chk("fbe status", rd[7:0] & 8'h5C, 8'h48);
        chk("iref st", rd[4], 1'b0);
        chk("fll ext ref", fll_ref_external, 1'b1);
        chk("ext trim", main_trim_active, 1'b0);
        edges(1'b1, n);
        chk("eref out", n > 0, 1'b1);
        apb(1'b1, OFS_CTRL3, 32'h20);
        ext_run <= 1'b0;
        n = 0;
        while (loss_flag !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk("loss flag", loss_flag, 1'b1);
        apb(1'b1, OFS_CTRL2, 32'h40);
        ext_run <= 1'b1;
        edges(1'b1, n);
        chk("eref off", n, 0);
        $display("test external done");
        print_verdict;
    end
endmodule
